//--- rtl/asg_group.v
// One status group: condition, transition filters, event latch and mask
`timescale 1ns/1ns
`include "asg_map.vh"

module asg_group #(
  parameter WIDTH = 16,
  parameter [WIDTH-1:0] COND_MASK = 16'h0000,
  parameter [WIDTH-1:0] PULSE_MASK = 16'h0000
) (
  clk,
  rst_b,
  ce,
  cond_in,
  pulse_in,
  wr_rise,
  wr_fall,
  wr_mask,
  wdata,
  rd_event,
  clr_status,
  cond_q,
  rise_q,
  fall_q,
  event_q,
  mask_q,
  summary
);
  input wire clk;
  input wire rst_b;
  input wire ce;
  input wire [WIDTH-1:0] cond_in;
  input wire [WIDTH-1:0] pulse_in;
  input wire wr_rise;
  input wire wr_fall;
  input wire wr_mask;
  input wire [WIDTH-1:0] wdata;
  input wire rd_event;
  input wire clr_status;
  output wire [WIDTH-1:0] cond_q;
  output wire [WIDTH-1:0] rise_q;
  output wire [WIDTH-1:0] fall_q;
  output wire [WIDTH-1:0] event_q;
  output wire [WIDTH-1:0] mask_q;
  output wire summary;

  reg [WIDTH-1:0] cond_r;
  reg [WIDTH-1:0] rise_r;
  reg [WIDTH-1:0] fall_r;
  reg [WIDTH-1:0] event_r;
  reg [WIDTH-1:0] mask_r;
  wire [WIDTH-1:0] set_w;
  wire [WIDTH-1:0] clear_w;

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection per bit; unused bits never set
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      assign set_w[i] = (COND_MASK[i] & ((cond_in[i] & ~cond_r[i] & rise_r[i]) |
                                         (~cond_in[i] & cond_r[i] & fall_r[i]))) |
                        (PULSE_MASK[i] & pulse_in[i]);
    end
  endgenerate

  // Read or clear-status wipes the latch, but a new event in that cycle survives
  assign clear_w = {WIDTH{rd_event | clr_status}};

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (!rst_b) begin
      cond_r <= {WIDTH{1'b0}};
      rise_r <= `ASG_RST_FILTER_RISE;
      fall_r <= `ASG_RST_FILTER_FALL;
      event_r <= `ASG_RST_EVENT;
      mask_r <= `ASG_RST_MASK;
    end else if (ce) begin
      cond_r <= cond_in & COND_MASK;
      if (wr_rise) begin
        rise_r <= wdata;
      end
      if (wr_fall) begin
        fall_r <= wdata;
      end
      if (wr_mask) begin
        mask_r <= wdata;
      end
      event_r <= (event_r & ~clear_w) | set_w;
    end
  end

  assign cond_q = cond_r;
  assign rise_q = rise_r;
  assign fall_q = fall_r;
  assign event_q = event_r;
  assign mask_q = mask_r;
  assign summary = |(event_r & mask_r);
endmodule

//--- rtl/asg_map.vh
// Register selectors, field positions and reset values of the two status groups
`ifndef ASG_MAP_VH
`define ASG_MAP_VH

// Group select
`define ASG_GRP_AUTH 1'b0
`define ASG_GRP_MSG 1'b1

// Register select within a group
`define ASG_REG_COND 3'h0
`define ASG_REG_RISE 3'h1
`define ASG_REG_FALL 3'h2
`define ASG_REG_EVENT 3'h3
`define ASG_REG_MASK 3'h4

// Authentication group fields
`define ASG_AUTH_BIT_IN_PROG 0
`define ASG_AUTH_BIT_SSD_UPD 1
`define ASG_AUTH_BIT_CHAL 2
`define ASG_AUTH_BIT_SSDA_ZERO 3
`define ASG_AUTH_BIT_REG_PASS 7
`define ASG_AUTH_BIT_PAGE_PASS 8
`define ASG_AUTH_BIT_ORIG_PASS 9
`define ASG_AUTH_BIT_CHAL_PASS 10
`define ASG_AUTH_BIT_SSD_PASS 11
`define ASG_AUTH_BIT_BURST 12
`define ASG_AUTH_COND_MASK 16'h000F
`define ASG_AUTH_PULSE_MASK 16'h1F80

// Message group fields
`define ASG_MSG_BIT_IN_PROG 0
`define ASG_MSG_BIT_ACK 1
`define ASG_MSG_COND_MASK 16'h0001
`define ASG_MSG_PULSE_MASK 16'h0002

// Reset values
`define ASG_RST_FILTER_RISE 16'hFFFF
`define ASG_RST_FILTER_FALL 16'h0000
`define ASG_RST_EVENT 16'h0000
`define ASG_RST_MASK 16'h0000

`endif

//--- rtl/asg_status.v
// Authentication and short-message status groups behind a status command port
`timescale 1ns/1ns
`include "asg_map.vh"

module asg_status #(
  parameter WIDTH = 16
) (
  clk,
  rst_b,
  ce,
  auth_in_progress,
  auth_ssd_update,
  auth_challenge,
  auth_ssda_zero,
  auth_reg_pass,
  auth_page_pass,
  auth_orig_pass,
  auth_chal_pass,
  auth_ssd_pass,
  auth_burst_result,
  msg_sent,
  msg_ack,
  cmd_valid,
  cmd_write,
  cmd_group,
  cmd_reg,
  cmd_wdata,
  clr_status,
  rsp_valid,
  rsp_data,
  auth_summary,
  msg_summary
);
  input wire clk;
  input wire rst_b;
  input wire ce;
  input wire auth_in_progress;
  input wire auth_ssd_update;
  input wire auth_challenge;
  input wire auth_ssda_zero;
  input wire auth_reg_pass;
  input wire auth_page_pass;
  input wire auth_orig_pass;
  input wire auth_chal_pass;
  input wire auth_ssd_pass;
  input wire auth_burst_result;
  input wire msg_sent;
  input wire msg_ack;
  input wire cmd_valid;
  input wire cmd_write;
  input wire cmd_group;
  input wire [2:0] cmd_reg;
  input wire [WIDTH-1:0] cmd_wdata;
  input wire clr_status;
  output reg rsp_valid;
  output reg [WIDTH-1:0] rsp_data;
  output reg auth_summary;
  output reg msg_summary;

  reg msg_pend_r;
  reg [WIDTH-1:0] auth_cond;
  reg [WIDTH-1:0] auth_pulse;
  reg [WIDTH-1:0] msg_cond;
  reg [WIDTH-1:0] msg_pulse;
  reg [WIDTH-1:0] rd_nxt;
  wire sel_auth;
  wire sel_msg;
  wire wr_go;
  wire rd_go;
  wire [WIDTH-1:0] a_cond;
  wire [WIDTH-1:0] a_rise;
  wire [WIDTH-1:0] a_fall;
  wire [WIDTH-1:0] a_event;
  wire [WIDTH-1:0] a_mask;
  wire a_sum;
  wire [WIDTH-1:0] m_cond;
  wire [WIDTH-1:0] m_rise;
  wire [WIDTH-1:0] m_fall;
  wire [WIDTH-1:0] m_event;
  wire [WIDTH-1:0] m_mask;
  wire m_sum;

  ////////////////////////////////////////////////////////////////////////////
  // Message pending: set by send, dropped by acknowledge; ack wins a tie
  always @(posedge clk) begin
    if (!rst_b) begin
      msg_pend_r <= 1'b0;
    end else if (ce) begin
      if (msg_ack) begin
        msg_pend_r <= 1'b0;
      end else if (msg_sent) begin
        msg_pend_r <= 1'b1;
      end
    end
  end

  always @* begin
    auth_cond = {WIDTH{1'b0}};
    auth_cond[`ASG_AUTH_BIT_IN_PROG] = auth_in_progress;
    auth_cond[`ASG_AUTH_BIT_SSD_UPD] = auth_ssd_update;
    auth_cond[`ASG_AUTH_BIT_CHAL] = auth_challenge;
    auth_cond[`ASG_AUTH_BIT_SSDA_ZERO] = auth_ssda_zero;
    auth_pulse = {WIDTH{1'b0}};
    auth_pulse[`ASG_AUTH_BIT_REG_PASS] = auth_reg_pass;
    auth_pulse[`ASG_AUTH_BIT_PAGE_PASS] = auth_page_pass;
    auth_pulse[`ASG_AUTH_BIT_ORIG_PASS] = auth_orig_pass;
    auth_pulse[`ASG_AUTH_BIT_CHAL_PASS] = auth_chal_pass;
    auth_pulse[`ASG_AUTH_BIT_SSD_PASS] = auth_ssd_pass;
    auth_pulse[`ASG_AUTH_BIT_BURST] = auth_burst_result;
    msg_cond = {WIDTH{1'b0}};
    msg_cond[`ASG_MSG_BIT_IN_PROG] = msg_pend_r;
    msg_pulse = {WIDTH{1'b0}};
    msg_pulse[`ASG_MSG_BIT_ACK] = msg_ack;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode
  assign sel_auth = (cmd_group == `ASG_GRP_AUTH);
  assign sel_msg = (cmd_group == `ASG_GRP_MSG);
  assign wr_go = cmd_valid & cmd_write;
  assign rd_go = cmd_valid & ~cmd_write;

  asg_group #(
    .WIDTH(WIDTH),
    .COND_MASK(`ASG_AUTH_COND_MASK),
    .PULSE_MASK(`ASG_AUTH_PULSE_MASK)
  ) u_auth (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .cond_in(auth_cond),
    .pulse_in(auth_pulse),
    .wr_rise(wr_go & sel_auth & (cmd_reg == `ASG_REG_RISE)),
    .wr_fall(wr_go & sel_auth & (cmd_reg == `ASG_REG_FALL)),
    .wr_mask(wr_go & sel_auth & (cmd_reg == `ASG_REG_MASK)),
    .wdata(cmd_wdata),
    .rd_event(rd_go & sel_auth & (cmd_reg == `ASG_REG_EVENT)),
    .clr_status(clr_status),
    .cond_q(a_cond),
    .rise_q(a_rise),
    .fall_q(a_fall),
    .event_q(a_event),
    .mask_q(a_mask),
    .summary(a_sum)
  );

  asg_group #(
    .WIDTH(WIDTH),
    .COND_MASK(`ASG_MSG_COND_MASK),
    .PULSE_MASK(`ASG_MSG_PULSE_MASK)
  ) u_msg (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .cond_in(msg_cond),
    .pulse_in(msg_pulse),
    .wr_rise(wr_go & sel_msg & (cmd_reg == `ASG_REG_RISE)),
    .wr_fall(wr_go & sel_msg & (cmd_reg == `ASG_REG_FALL)),
    .wr_mask(wr_go & sel_msg & (cmd_reg == `ASG_REG_MASK)),
    .wdata(cmd_wdata),
    .rd_event(rd_go & sel_msg & (cmd_reg == `ASG_REG_EVENT)),
    .clr_status(clr_status),
    .cond_q(m_cond),
    .rise_q(m_rise),
    .fall_q(m_fall),
    .event_q(m_event),
    .mask_q(m_mask),
    .summary(m_sum)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; the event value returned is the one held before the clear lands
  always @* begin
    rd_nxt = {WIDTH{1'b0}};
    case (cmd_reg)
      `ASG_REG_COND: rd_nxt = sel_auth ? a_cond : m_cond;
      `ASG_REG_RISE: rd_nxt = sel_auth ? a_rise : m_rise;
      `ASG_REG_FALL: rd_nxt = sel_auth ? a_fall : m_fall;
      `ASG_REG_EVENT: rd_nxt = sel_auth ? a_event : m_event;
      `ASG_REG_MASK: rd_nxt = sel_auth ? a_mask : m_mask;
      default: rd_nxt = {WIDTH{1'b0}};
    endcase
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      rsp_valid <= 1'b0;
      rsp_data <= {WIDTH{1'b0}};
      auth_summary <= 1'b0;
      msg_summary <= 1'b0;
    end else if (ce) begin
      rsp_valid <= rd_go;
      if (rd_go) begin
        rsp_data <= rd_nxt;
      end
      auth_summary <= a_sum;
      msg_summary <= m_sum;
    end
  end
endmodule

//--- verification/asg_ctrl_model.sv
// Remote controller issuing status queries and writes
`timescale 1ns/1ns
module asg_ctrl_model (
  input logic clk,
  output logic cmd_valid,
  output logic cmd_write,
  output logic cmd_group,
  output logic [2:0] cmd_reg,
  output logic [15:0] cmd_wdata
);
  initial begin
    cmd_valid = '0;
    cmd_write = '0;
    cmd_group = '0;
    cmd_reg = '0;
    cmd_wdata = '0;
  end
  // Valid stays up so commands can run back to back
  task cmd(input logic w, input logic g, input logic [2:0] r, input logic [15:0] d);
    @(negedge clk);
    cmd_valid = '1;
    cmd_write = w;
    cmd_group = g;
    cmd_reg = r;
    cmd_wdata = d;
  endtask
  task idle;
    @(negedge clk);
    cmd_valid = '0;
    cmd_wdata = ~cmd_wdata;
  endtask
endmodule

//--- verification/asg_status_monitor.sv
// Assertion checker on the status command port
`timescale 1ns/1ns
module asg_status_monitor (
  input logic clk,
  input logic rst_b,
  input logic ce,
  input logic msg_sent,
  input logic msg_ack,
  input logic cmd_valid,
  input logic cmd_write,
  input logic cmd_group,
  input logic [2:0] cmd_reg,
  input logic clr_status,
  input logic rsp_valid,
  input logic [15:0] rsp_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire q = ce && cmd_valid && !cmd_write;
  wire qm = q && cmd_group && cmd_reg == 3'h3;
  // Message inputs reach the event latch up to two cycles late
  wire quiet = ce && !msg_sent && !msg_ack;
  sequence s_rd_twice;
    quiet [*3] ##0 qm ##1 qm;
  endsequence
  sequence s_clr;
    quiet [*3] ##0 clr_status ##1 qm;
  endsequence
  sequence s_ack;
    ce && msg_ack ##1 qm;
  endsequence
  chk_query_answer: assert property (q |=> rsp_valid) else $error("no answer");
  chk_answer_cause: assert property (rsp_valid |-> $past(q)) else $error("stray answer");
  chk_rsp_hold: assert property (!rsp_valid |-> $stable(rsp_data)) else $error("data moved");
  chk_read_clear: assert property (s_rd_twice |=> rsp_data == 16'h0000) else $error("read kept");
  chk_clr_event: assert property (s_clr |=> rsp_data == 16'h0000) else $error("clear kept");
  chk_ack_event: assert property (s_ack |=> rsp_data[1]) else $error("ack lost");
  chk_auth_unused: assert property (
    rsp_valid && $past(!cmd_group && cmd_reg inside {3'h0, 3'h3}) |->
    rsp_data[15:13] == 3'h0 && rsp_data[6:4] == 3'h0) else $error("auth spare set");
  chk_msg_unused: assert property (
    rsp_valid && $past(cmd_group && cmd_reg inside {3'h0, 3'h3}) |->
    rsp_data[15:2] == 14'h0000) else $error("msg spare set");
endmodule
bind asg_status asg_status_monitor u_mon (.*);

//--- verification/auth_and_sms_status_groups_bench.sv
// Self-checking bench with a queue-based reference of both groups
`timescale 1ns/1ns
module auth_and_sms_status_groups_bench;
  logic clk = '0;
  logic rst_b = '0;
  logic clr = '0;
  logic ce = '1;
  logic snt = '0;
  logic ack = '0;
  logic [3:0] cnd = '0;
  logic [5:0] pls = '0;
  logic [15:0] rf [2], ff [2], ev [2], mk [2], cd [2], v;
  logic [15:0] q [$];
  integer seed = 61375;
  integer n_fail = 0;
  integer comparisons = 0;
  integer cyc = 0;
  integer i, g, r;
  wire cmd_valid, cmd_write, cmd_group, rsp_valid, auth_summary, msg_summary;
  wire [2:0] cmd_reg;
  wire [15:0] cmd_wdata, rsp_data;
  always #2 clk = ~clk;
  asg_ctrl_model u_ctl (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_group(cmd_group),
    .cmd_reg(cmd_reg), .cmd_wdata(cmd_wdata));
  asg_status u_dut (.clk(clk), .rst_b(rst_b), .ce(ce), .auth_in_progress(cnd[0]), .auth_ssd_update(cnd[1]),
    .auth_challenge(cnd[2]), .auth_ssda_zero(cnd[3]), .auth_reg_pass(pls[0]), .auth_page_pass(pls[1]),
    .auth_orig_pass(pls[2]), .auth_chal_pass(pls[3]), .auth_ssd_pass(pls[4]), .auth_burst_result(pls[5]),
    .msg_sent(snt), .msg_ack(ack), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_group(cmd_group),
    .cmd_reg(cmd_reg), .cmd_wdata(cmd_wdata), .clr_status(clr), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .auth_summary(auth_summary), .msg_summary(msg_summary));
  ////////////////////////////////////////
  task print_verdict;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task rd(input integer gg, input integer rr);
    u_ctl.cmd(1'h0, gg[0], rr[2:0], 16'h0000);
    v = 16'h0000;
    if (rr == 0) v = cd[gg];
    if (rr == 1) v = rf[gg];
    if (rr == 2) v = ff[gg];
    if (rr == 3) v = ev[gg];
    if (rr == 3) ev[gg] = 16'h0000;
    if (rr == 4) v = mk[gg];
    q.push_back(v);
  endtask
  task wr(input integer gg, input integer rr, input logic [15:0] d);
    u_ctl.cmd(1'h1, gg[0], rr[2:0], d);
    if (rr == 1) rf[gg] = d;
    if (rr == 2) ff[gg] = d;
    if (rr == 4) mk[gg] = d;
  endtask
  // Sets landing with a clear survive it, so the clear goes first
  // A low enable loses the pulses; level conditions are still seen one cycle later
  task stim(input logic [15:0] s);
    logic [15:0] nm;
    u_ctl.idle;
    {clr, ack, snt, pls, cnd} = {s[13] & s[12], s[11:0]};
    ce = s[15] | s[14];
    nm = {15'h0000, (ack & ce) ? 1'h0 : ((snt & ce) | cd[1][0])};
    ev[0] = ((clr & ce) ? 16'h0000 : ev[0]) | {3'h0, pls & {6{ce}}, 3'h0, (~cd[0][3:0] & cnd & rf[0][3:0])
      | (cd[0][3:0] & ~cnd & ff[0][3:0])};
    ev[1] = ((clr & ce) ? 16'h0000 : ev[1]) | {14'h0000, ack & ce, (~cd[1][0] & nm[0] & rf[1][0])
      | (cd[1][0] & ~nm[0] & ff[1][0])};
    cd[0] = {12'h000, cnd};
    cd[1] = nm;
    @(negedge clk);
    {clr, ack, snt, pls} = '0;
    ce = '1;
    repeat (3) @(negedge clk);
  endtask
  always @(negedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      print_verdict;
    end
    if (rsp_valid === 1'h1 && q.size() > 0) check(rsp_data, q.pop_front());
  end
  task do_reset(input integer n);
    rst_b = '0;
    for (g = 0; g < 2; g++) begin
      rf[g] = 16'hFFFF;
      ff[g] = 16'h0000;
      ev[g] = 16'h0000;
      mk[g] = 16'h0000;
      cd[g] = 16'h0000;
    end
    repeat (n) @(negedge clk);
    rst_b = '1;
    for (r = 0; r < 8; r++) begin
      rd(0, r);
      rd(1, r);
    end
  endtask
  initial begin
    do_reset(16);
    for (i = 0; i < 40; i++) begin
      g = {$random(seed)} % 2;
      r = {$random(seed)} % 5;
      wr(g, r, 16'($random(seed)));
      stim(16'($random(seed)));
      check({15'h0000, auth_summary}, {15'h0000, |(ev[0] & mk[0])});
      check({15'h0000, msg_summary}, {15'h0000, |(ev[1] & mk[1])});
      rd(0, 0);
      rd(0, 3);
      rd(1, 0);
      rd(1, 3);
      rd(g, r);
    end
    // Mid-run reset with the conditions low, so no false edge follows the release
    u_ctl.idle;
    cnd = '0;
    do_reset(3);
    check({14'h0000, auth_summary, msg_summary}, 16'h0000);
    // Acknowledge straight before an event query
    u_ctl.idle;
    ack = '1;
    ev[1] = ev[1] | 16'h0002;
    rd(1, 3);
    ack = '0;
    // Acknowledge, three quiet cycles, then a clear straight before an event query
    u_ctl.idle;
    ack = '1;
    ev[1] = ev[1] | 16'h0002;
    @(negedge clk);
    ack = '0;
    repeat (3) @(negedge clk);
    clr = '1;
    ev[0] = 16'h0000;
    ev[1] = 16'h0000;
    rd(1, 3);
    clr = '0;
    u_ctl.idle;
    repeat (3) @(negedge clk);
    check(16'(q.size()), 16'h0000);
    print_verdict;
  end
endmodule
